/* File: design/flash_ctrl_pkg.sv */
// constants shared by the flash program/erase control block
package flash_ctrl_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam logic [31:0] MODE_CONTROL_ADDR = 32'hFFFF8580;
    localparam logic [31:0] ERROR_STATUS_ADDR = 32'hFFFF8581;
    localparam logic [31:0] ERASE_BLOCK_ADDR = 32'hFFFF8582;
    localparam logic [31:0] EMULATION_ADDR = 32'hFFFF8584;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hFFFF8588;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hFFFF858C;
    localparam int FWE_BIT = 7;
    localparam int SWE_BIT = 6;
    localparam int ESU_BIT = 5;
    localparam int PSU_BIT = 4;
    localparam int EV_BIT = 3;
    localparam int PV_BIT = 2;
    localparam int ERASE_BIT = 1;
    localparam int PROG_BIT = 0;
    localparam int ERR_BIT = 7;
    localparam int EMU_SEL_BIT = 2;
    localparam int EMU_HI_BIT = 1;
    localparam int EMU_LO_BIT = 0;
    localparam logic [6:0] MODE_RESET = 7'h00;
    localparam logic [7:0] BLOCK_RESET = 8'h00;
    localparam logic [2:0] EMU_RESET = 3'h0;
    // irq status bits: error raised, protect pin dropped
    localparam int IRQ_W = 2;
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_WP_BIT = 1;
    localparam logic [23:0] RAM_WINDOW_BASE = 24'hFFF800;
    localparam logic [23:0] EMU_FLASH_BASE = 24'h01F000;
    localparam logic [23:0] EMU_BLOCK_SIZE = 24'h000400;
endpackage

/* File: design/pin_sync.sv */
// two flop synchroniser for an asynchronous pin level
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: design/flash_program_erase_control.sv */
// flash program/erase control and status registers
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_control (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [flash_ctrl_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [flash_ctrl_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [flash_ctrl_pkg::DATA_W-1:0] bus_rdata,
    input wire logic write_protect_pin,
    input wire logic flash_fault,
    output logic erase_mode,
    output logic program_mode,
    output logic erase_verify_mode,
    output logic program_verify_mode,
    output logic erase_setup_out,
    output logic program_setup_out,
    output logic [7:0] erase_open,
    output logic [23:0] ram_window_base,
    output logic irq
);
    import flash_ctrl_pkg::*;

    logic wp_sync;
    logic fwe_q;
    logic [6:0] mode_q;
    logic [6:0] mode_d;
    logic err_q;
    logic [7:0] block_q;
    logic [2:0] emu_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_ev;
    logic fwe_prev_q;
    logic protect;
    logic sel_mode, sel_err, sel_block, sel_emu, sel_stat, sel_mask;
    logic [DATA_W-1:0] rd_d;

    pin_sync u_wp_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(write_protect_pin),
        .sync_out(wp_sync)
    );

    assign sel_mode = bus_addr == MODE_CONTROL_ADDR;
    assign sel_err = bus_addr == ERROR_STATUS_ADDR;
    assign sel_block = bus_addr == ERASE_BLOCK_ADDR;
    assign sel_emu = bus_addr == EMULATION_ADDR;
    assign sel_stat = bus_addr == IRQ_STATUS_ADDR;
    assign sel_mask = bus_addr == IRQ_MASK_ADDR;

    // registered copy keeps the read-back and gating in step
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fwe_q <= 1'b0;
        end else begin
            fwe_q <= wp_sync;
        end
    end

    // error and emulation both block program and erase
    assign protect = err_q || emu_q[EMU_SEL_BIT];

    always_comb begin
        logic en;
        en = fwe_q && mode_q[SWE_BIT];
        mode_d = mode_q;
        if (bus_write && sel_mode) begin
            // a bit only rises when its setting condition holds
            mode_d[SWE_BIT] = bus_wdata[SWE_BIT] && fwe_q;
            mode_d[ESU_BIT] = bus_wdata[ESU_BIT] && en;
            mode_d[PSU_BIT] = bus_wdata[PSU_BIT] && en;
            mode_d[EV_BIT] = bus_wdata[EV_BIT];
            mode_d[PV_BIT] = bus_wdata[PV_BIT] && en;
            mode_d[ERASE_BIT] = bus_wdata[ERASE_BIT] && en
                && mode_q[ESU_BIT] && !protect;
            mode_d[PROG_BIT] = bus_wdata[PROG_BIT] && en
                && !protect;
        end
        // losing the pin drops every enable
        if (!fwe_q) begin
            mode_d = MODE_RESET;
        end
        if (protect) begin
            mode_d[ERASE_BIT] = 1'b0;
            mode_d[PROG_BIT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // only reset clears the flag; no bus path reaches it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            err_q <= 1'b0;
        end else if (flash_fault
            && (mode_q[ERASE_BIT] || mode_q[PROG_BIT])) begin
            err_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            block_q <= BLOCK_RESET;
        end else if (bus_write && sel_block) begin
            block_q <= bus_wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            emu_q <= EMU_RESET;
        end else if (bus_write && sel_emu) begin
            emu_q <= bus_wdata[2:0];
        end
    end

    // sticky events: error rising, protect pin falling
    assign irq_ev[IRQ_ERR_BIT] = flash_fault
        && (mode_q[ERASE_BIT] || mode_q[PROG_BIT]) && !err_q;
    assign irq_ev[IRQ_WP_BIT] = fwe_prev_q && !fwe_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fwe_prev_q <= 1'b0;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            fwe_prev_q <= fwe_q;
            // set wins over a same-cycle clear
            if (bus_write && sel_stat) begin
                irq_stat_q <= (irq_stat_q & ~bus_wdata[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
            if (bus_write && sel_mask) begin
                irq_mask_q <= bus_wdata[IRQ_W-1:0];
            end
        end
    end

    always_comb begin
        rd_d = '0;
        if (sel_mode) begin
            rd_d[7:0] = {fwe_q, mode_q};
        end else if (sel_err) begin
            rd_d[ERR_BIT] = err_q;
        end else if (sel_block) begin
            rd_d[7:0] = block_q;
        end else if (sel_emu) begin
            rd_d[2:0] = emu_q;
        end else if (sel_stat) begin
            rd_d[IRQ_W-1:0] = irq_stat_q;
        end else if (sel_mask) begin
            rd_d[IRQ_W-1:0] = irq_mask_q;
        end
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= '0;
        end else if (bus_read) begin
            bus_rdata <= rd_d;
        end else begin
            bus_rdata <= '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            erase_mode <= 1'b0;
            program_mode <= 1'b0;
            erase_verify_mode <= 1'b0;
            program_verify_mode <= 1'b0;
            erase_setup_out <= 1'b0;
            program_setup_out <= 1'b0;
            ram_window_base <= RAM_WINDOW_BASE;
            irq <= 1'b0;
        end else begin
            erase_mode <= mode_d[ERASE_BIT];
            program_mode <= mode_d[PROG_BIT];
            erase_verify_mode <= mode_d[EV_BIT];
            program_verify_mode <= mode_d[PV_BIT];
            erase_setup_out <= mode_d[ESU_BIT];
            program_setup_out <= mode_d[PSU_BIT];
            if (emu_q[EMU_SEL_BIT]) begin
                ram_window_base <= EMU_FLASH_BASE + EMU_BLOCK_SIZE
                    * {22'h0, emu_q[EMU_HI_BIT], emu_q[EMU_LO_BIT]};
            end else begin
                ram_window_base <= RAM_WINDOW_BASE;
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // one gate per erase block; either protection closes them all
    for (genvar b = 0; b < 8; b++) begin : g_block_gate
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                erase_open[b] <= 1'b0;
            end else begin
                erase_open[b] <= block_q[b] && !protect;
            end
        end
        AST_BLOCK_GATE: assert property (
            @(posedge ref_clk) disable iff (!rstn)
            erase_open[b] |-> $past(block_q[b]) && !$past(protect))
            else $error("erase block open while protected");
    end

    AST_PROG_NEEDS_EN: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[PROG_BIT]) |-> $past(fwe_q && mode_q[SWE_BIT]))
        else $error("program mode set without enables");
    AST_ERASE_NEEDS_SETUP: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[ERASE_BIT]) |-> $past(mode_q[ESU_BIT]))
        else $error("erase mode set without setup");
    AST_SWE_NEEDS_FWE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        mode_q[SWE_BIT] |-> $past(fwe_q))
        else $error("software enable without write enable");
    AST_ESU_EN: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[ESU_BIT]) |-> $past(fwe_q && mode_q[SWE_BIT]))
        else $error("erase setup set without enables");
    AST_PSU_EN: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[PSU_BIT]) |-> $past(fwe_q && mode_q[SWE_BIT]))
        else $error("program setup set without enables");
    AST_PV_EN: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[PV_BIT]) |-> $past(fwe_q && mode_q[SWE_BIT]))
        else $error("program verify set without enables");
    AST_EV_WRITE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        bus_write && sel_mode && fwe_q
        |=> mode_q[EV_BIT] == $past(bus_wdata[EV_BIT]))
        else $error("erase verify did not follow write");
    AST_ERR_STICKY: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        err_q |=> err_q ##1 err_q)
        else $error("error flag cleared without reset");
    AST_ERR_PROTECT: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        err_q |=> !mode_q[PROG_BIT] && !mode_q[ERASE_BIT])
        else $error("program or erase under error protection");
    AST_FWE_PIN: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        sel_mode && bus_read |=> bus_rdata[FWE_BIT] == $past(fwe_q))
        else $error("write enable read-back wrong");
    AST_UNUSED_ZERO: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        bus_read && sel_emu |=> bus_rdata[15:3] == 13'h0000)
        else $error("unused bits not zero");
    AST_BLOCK_OPEN: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        emu_q[EMU_SEL_BIT] |=> erase_open == 8'h00)
        else $error("blocks open during emulation");
    AST_WINDOW: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !emu_q[EMU_SEL_BIT] |=> ram_window_base == RAM_WINDOW_BASE)
        else $error("ram window moved without emulation");
    AST_RESET_MODE: assert property (
        @(posedge ref_clk)
        $rose(rstn) |-> mode_q == MODE_RESET && block_q == 8'h00)
        else $error("mode not clear after reset");
    AST_ERASE_EN: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[ERASE_BIT]) |-> $past(fwe_q && mode_q[SWE_BIT]))
        else $error("erase mode set without enables");
    AST_PROG_PROTECT: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[PROG_BIT]) |-> !$past(protect))
        else $error("program mode set under protection");
    AST_ERASE_PROTECT: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[ERASE_BIT]) |-> !$past(protect))
        else $error("erase mode set under protection");
    AST_EMU_PROTECT: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        emu_q[EMU_SEL_BIT] |=> !mode_q[PROG_BIT] && !mode_q[ERASE_BIT])
        else $error("program or erase during emulation");
    AST_FWE_DROP: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !fwe_q |=> mode_q == MODE_RESET)
        else $error("mode bits kept without write enable");
    AST_FWE_FOLLOWS: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        fwe_q == $past(wp_sync))
        else $error("write enable does not follow pin");
    AST_ERR_CAUSE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(err_q)
        |-> $past(flash_fault && (mode_q[ERASE_BIT] || mode_q[PROG_BIT])))
        else $error("error flag set without a fault");
    AST_ERR_SETS: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        flash_fault && (mode_q[ERASE_BIT] || mode_q[PROG_BIT]) |=> err_q)
        else $error("fault during program or erase not flagged");
    AST_BLOCK_WRITE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        bus_write && sel_block |=> block_q == $past(bus_wdata[7:0]))
        else $error("block select write lost");
    AST_EMU_WRITE: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        bus_write && sel_emu |=> emu_q == $past(bus_wdata[2:0]))
        else $error("emulation select write lost");
    AST_WINDOW_EMU: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        emu_q[EMU_SEL_BIT] |=> ram_window_base
            == EMU_FLASH_BASE + EMU_BLOCK_SIZE * {22'h0, $past(emu_q[1:0])})
        else $error("ram window not over chosen block");
    AST_ERR_READ: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        bus_read && sel_err |=> bus_rdata == {8'h00, $past(err_q), 7'h00})
        else $error("error status read-back wrong");
    AST_UNMAPPED_ZERO: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        bus_read && !(sel_mode || sel_err || sel_block || sel_emu
        || sel_stat || sel_mask) |=> bus_rdata == 16'h0000)
        else $error("unmapped read not zero");

    COV_PROGRAM: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[PROG_BIT]));
    COV_ERASE: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(mode_q[ERASE_BIT]));
    COV_ERROR: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(err_q));
    COV_EMULATION: cover property (@(posedge ref_clk) disable iff (!rstn)
        emu_q == 3'h7);
    COV_FWE_LOST: cover property (@(posedge ref_clk) disable iff (!rstn)
        $fell(fwe_q));
endmodule
`default_nettype wire

/* File: dv/flash_array_model.sv */
// stand-in for the flash array and the write protect pin
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
    input wire logic ref_clk,
    input wire logic pin_level,
    input wire logic fault_req,
    output logic write_protect_pin,
    output logic flash_fault
);
    // pin is asynchronous, so it moves off the clock edge
    assign #3 write_protect_pin = pin_level;
    always_ff @(posedge ref_clk) begin
        flash_fault <= fault_req;
    end
endmodule
`default_nettype wire

/* File: dv/flash_program_erase_control_bench.sv */
// self-checking bench for the flash program/erase control block
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_control_bench;
    import flash_ctrl_pkg::*;
    logic ref_clk = 0, rstn = 0, bus_write = 0, bus_read = 0;
    logic pin_level = 1, fault_req = 0;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [DATA_W-1:0] bus_wdata = '0;
    logic [DATA_W-1:0] bus_rdata;
    logic write_protect_pin, flash_fault, erase_mode, program_mode, irq;
    logic erase_verify_mode, program_verify_mode;
    logic erase_setup_out, program_setup_out;
    logic [7:0] erase_open;
    logic [23:0] ram_window_base;
    logic [31:0] r;
    int fail_count = 0, comparisons = 0, cycles = 0, i;
    int seed = 32'h2194692D;
    int m_mode, m_fwe, m_err, m_blk, m_emu, m_ist, m_msk;

    flash_program_erase_control flash_program_erase_control_i (
        .ref_clk, .rstn, .bus_addr, .bus_wdata, .bus_write, .bus_read,
        .bus_rdata, .write_protect_pin, .flash_fault, .erase_mode,
        .program_mode, .erase_verify_mode, .program_verify_mode,
        .erase_setup_out, .program_setup_out, .erase_open,
        .ram_window_base, .irq
    );
    flash_array_model flash_array_model_i (
        .ref_clk, .pin_level, .fault_req, .write_protect_pin, .flash_fault
    );

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            end_sim;
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input int d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d[15:0];
        bus_write <= 1'b1;
        @(posedge ref_clk);
        bus_write <= 1'b0;
    endtask

    task automatic rc(input logic [31:0] a, input int e);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge ref_clk);
        bus_read <= 1'b0;
        #1 check({8'h00, bus_rdata}, e[23:0]);
    endtask

    // setting conditions see the register as it was before the write
    function automatic int mode_next(input int w);
        int n;
        n = 0;
        if (m_fwe) begin
            n = w & 'h48;
            if (m_mode[6]) n |= w & 'h35;
            if (m_mode[6] && m_mode[5]) n |= w & 'h02;
        end
        return n;
    endfunction

    task automatic mwr(input logic [31:0] a, input int d);
        wr(a, d);
        case (a)
            MODE_CONTROL_ADDR: m_mode = mode_next(d);
            ERASE_BLOCK_ADDR: m_blk = d & 'hFF;
            EMULATION_ADDR: m_emu = d & 7;
            IRQ_STATUS_ADDR: m_ist &= ~d;
            IRQ_MASK_ADDR: m_msk = d & 3;
            default: ;
        endcase
        if (m_err || m_emu[2]) m_mode &= ~3;
    endtask

    task automatic chk_all;
        int blk;
        blk = (m_err || m_emu[2]) ? 0 : m_blk;
        rc(MODE_CONTROL_ADDR, m_fwe * 'h80 + m_mode);
        rc(ERROR_STATUS_ADDR, m_err * 'h80);
        rc(ERASE_BLOCK_ADDR, m_blk);
        rc(EMULATION_ADDR, m_emu);
        rc(IRQ_STATUS_ADDR, m_ist);
        rc(IRQ_MASK_ADDR, m_msk);
        rc(32'hFFFF8590, 0);
        check({erase_setup_out, program_setup_out, erase_verify_mode,
            program_verify_mode, erase_mode, program_mode},
            24'(m_mode & 'h3F));
        check(erase_open, blk[23:0]);
        check(ram_window_base, m_emu[2] ? EMU_FLASH_BASE +
            EMU_BLOCK_SIZE * m_emu[1:0] : RAM_WINDOW_BASE);
        check(irq, |(m_ist & m_msk));
    endtask

    task automatic set_pin(input logic v);
        @(posedge ref_clk);
        pin_level <= v;
        repeat (6) @(posedge ref_clk);
        if (m_fwe && !v) begin
            m_mode = 0;
            m_ist |= 2;
        end
        m_fwe = v;
    endtask

    // a fault only counts while program or erase is running
    task automatic fault;
        @(posedge ref_clk);
        fault_req <= 1'b1;
        @(posedge ref_clk);
        fault_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        if (m_mode & 3) begin
            if (!m_err) m_ist |= 1;
            m_err = 1;
            m_mode &= ~3;
        end
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        {m_mode, m_err, m_blk, m_emu, m_ist, m_msk} = '0;
        m_fwe = pin_level;
    endtask

    initial begin
        do_reset;
        chk_all;
        set_pin(0);
        mwr(MODE_CONTROL_ADDR, 'hFF);
        chk_all;
        set_pin(1);
        for (i = 0; i < 150; i++) begin
            r = $random(seed);
            case (r[2:0])
                0: set_pin(r[3] | r[4]);
                1: mwr(ERASE_BLOCK_ADDR, r[31:16]);
                2: mwr(EMULATION_ADDR, r[31:16] & (r[5] ? 'hFFFF : 'hFFFB));
                3: mwr(IRQ_MASK_ADDR, r[31:16]);
                4: mwr(IRQ_STATUS_ADDR, r[31:16]);
                5: mwr(r[3] ? ERROR_STATUS_ADDR : 32'hFFFF8590, r[31:16]);
                default: mwr(MODE_CONTROL_ADDR, r[9] ? 'hFF : r[31:16]);
            endcase
            chk_all;
        end
        mwr(EMULATION_ADDR, 0);
        set_pin(1);
        mwr(IRQ_MASK_ADDR, 3);
        mwr(IRQ_STATUS_ADDR, 3);
        mwr(MODE_CONTROL_ADDR, 0);
        fault;
        chk_all;
        mwr(MODE_CONTROL_ADDR, 'h40);
        mwr(MODE_CONTROL_ADDR, 'h11);
        fault;
        mwr(ERROR_STATUS_ADDR, 0);
        // enables back on, so only the error flag can refuse program
        mwr(MODE_CONTROL_ADDR, 'h40);
        mwr(MODE_CONTROL_ADDR, 'h51);
        chk_all;
        mwr(IRQ_STATUS_ADDR, 1);
        set_pin(0);
        chk_all;
        do_reset;
        chk_all;
        end_sim;
    end
endmodule
`default_nettype wire
